// ===== verilog/prad_dev.sv
// Notes on behaviour
// - Global reset floats outputs, clears all state
// - All bus signals sampled on rising clock
// - Bus reset floats outputs, clears registers
// - Suspend with bus reset keeps registers
// - Lanes carry address, then data
// - Command lanes: command, then byte enables
// - Byte enable n qualifies byte n
// - Even parity over data and command lanes
// - Initiator drives parity one clock later
// - Target flags parity mismatch on error line
// - Error reported only when enable bit set
module prad_dev (
    input  wire logic        CLK,
    input  wire logic        RSTN,
    prad_if.dev              bus,
    input  wire logic [31:0] TX_ADDR,
    input  wire logic [3:0]  TX_CMD,
    input  wire logic [31:0] TX_DATA,
    input  wire logic [3:0]  TX_BE_N,
    input  wire logic        CFG_WE,
    input  wire logic [15:0] CFG_CMD_WDATA,
    output logic      [15:0] CFG_CMD,
    output logic      [31:0] RX_ADDR,
    output logic      [3:0]  RX_CMD,
    output logic      [31:0] RX_DATA,
    output logic             RX_DATA_VLD,
    output logic             PERR_SEEN
);
    ////////////////////////////////////////////////////////////////////////
    logic        hard_rst;
    logic        soft_rst;
    logic        float_all;
    logic        ini_addr;
    logic        ini_data;
    logic        tgt_addr;
    logic        tgt_data;
    // Registered state, next value beside it
    logic [15:0] cmd_q,      cmd_d;
    logic [31:0] rx_addr_q,  rx_addr_d;
    logic [3:0]  rx_cmd_q,   rx_cmd_d;
    logic [31:0] rx_data_q,  rx_data_d;
    logic        rx_vld_q,   rx_vld_d;
    logic        seen_q,     seen_d;
    logic [31:0] ad_q,       ad_d;
    logic [3:0]  cbe_q,      cbe_d;
    logic        lane_oe_q,  lane_oe_d;
    logic        par_q,      par_d;
    logic        par_oe_q,   par_oe_d;
    logic        chk_q,      chk_d;
    logic        exp_par_q,  exp_par_d;
    logic        perr_q,     perr_d;
    logic        perr_oe_q,  perr_oe_d;

    // Keep disabled byte lanes, take enabled ones
    function automatic logic [31:0] lane_merge(
        input logic [31:0] old_word,
        input logic [31:0] new_word,
        input logic [3:0]  be_n
    );
        logic [31:0] sel;
        sel        = prad_pkg::prad_lane_mask(be_n);
        lane_merge = (old_word & ~sel) | (new_word & sel);
    endfunction

    assign hard_rst  = !RSTN || bus.global_reset_in;
    assign soft_rst  = bus.bus_reset_in && !bus.suspend_in;
    assign float_all = hard_rst || bus.bus_reset_in;
    assign ini_addr  = bus.dev_initiator && bus.addr_phase;
    assign ini_data  = bus.dev_initiator && bus.data_phase;
    assign tgt_addr  = !bus.dev_initiator && bus.addr_phase;
    assign tgt_data  = !bus.dev_initiator && bus.data_phase;

    ////////////////////////////////////////////////////////////////////////
    // Command register and target capture
    always_comb begin
        cmd_d     = cmd_q;
        rx_addr_d = rx_addr_q;
        rx_cmd_d  = rx_cmd_q;
        rx_data_d = rx_data_q;
        rx_vld_d  = 1'b0;
        if (CFG_WE) begin
            cmd_d = CFG_CMD_WDATA;
        end
        if (!float_all) begin
            // Target samples lanes on this edge
            if (tgt_addr) begin
                rx_addr_d = bus.ad;
                rx_cmd_d  = bus.cbe;
            end
            // Only enabled byte lanes are taken
            if (tgt_data) begin
                rx_data_d = lane_merge(rx_data_q, bus.ad, bus.cbe);
                rx_vld_d  = 1'b1;
            end
        end
        if (hard_rst || soft_rst) begin
            cmd_d     = prad_pkg::CMD_RST;
            rx_addr_d = prad_pkg::AD_RST;
            rx_cmd_d  = prad_pkg::CBE_RST;
            rx_data_d = prad_pkg::AD_RST;
        end
    end

    always_ff @(posedge CLK) begin
        cmd_q     <= cmd_d;
        rx_addr_q <= rx_addr_d;
        rx_cmd_q  <= rx_cmd_d;
        rx_data_q <= rx_data_d;
        rx_vld_q  <= rx_vld_d;
    end

    ////////////////////////////////////////////////////////////////////////
    // Initiator lanes and parity
    always_comb begin
        ad_d      = prad_pkg::AD_RST;
        cbe_d     = prad_pkg::CBE_RST;
        lane_oe_d = 1'b0;
        par_d     = 1'b0;
        par_oe_d  = 1'b0;
        if (!float_all) begin
            if (ini_addr) begin
                ad_d      = TX_ADDR;
                cbe_d     = TX_CMD;
                lane_oe_d = 1'b1;
            end
            if (ini_data) begin
                ad_d      = TX_DATA;
                cbe_d     = TX_BE_N;
                lane_oe_d = 1'b1;
            end
            // Parity follows driven lanes by one clock
            if (lane_oe_q) begin
                par_d    = prad_pkg::prad_even_par(ad_q, cbe_q);
                par_oe_d = 1'b1;
            end
        end
    end

    always_ff @(posedge CLK) begin
        ad_q      <= ad_d;
        cbe_q     <= cbe_d;
        lane_oe_q <= lane_oe_d;
        par_q     <= par_d;
        par_oe_q  <= par_oe_d;
    end

    ////////////////////////////////////////////////////////////////////////
    // Target parity check and error report
    always_comb begin
        seen_d    = seen_q;
        chk_d     = 1'b0;
        exp_par_d = 1'b0;
        perr_d    = 1'b1;
        perr_oe_d = 1'b0;
        if (!float_all) begin
            if (tgt_addr || tgt_data) begin
                chk_d     = 1'b1;
                exp_par_d = prad_pkg::prad_even_par(bus.ad, bus.cbe);
            end
            // Compare with initiator parity next clock
            if (chk_q && (bus.par != exp_par_q)) begin
                seen_d = 1'b1;
                if (cmd_q[prad_pkg::PERR_EN_BIT]) begin
                    perr_d    = 1'b0;
                    perr_oe_d = 1'b1;
                end
            end
        end
        if (hard_rst || soft_rst) begin
            seen_d = 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        seen_q    <= seen_d;
        chk_q     <= chk_d;
        exp_par_q <= exp_par_d;
        perr_q    <= perr_d;
        perr_oe_q <= perr_oe_d;
    end

    ////////////////////////////////////////////////////////////////////////
    // Pins and status straight from flops
    assign bus.ad_dev      = ad_q;
    assign bus.ad_dev_oe   = lane_oe_q;
    assign bus.cbe_dev     = cbe_q;
    assign bus.cbe_dev_oe  = lane_oe_q;
    assign bus.par_dev     = par_q;
    assign bus.par_dev_oe  = par_oe_q;
    assign bus.perr_n_dev  = perr_q;
    assign bus.perr_dev_oe = perr_oe_q;
    assign CFG_CMD         = cmd_q;
    assign RX_ADDR         = rx_addr_q;
    assign RX_CMD          = rx_cmd_q;
    assign RX_DATA         = rx_data_q;
    assign RX_DATA_VLD     = rx_vld_q;
    assign PERR_SEEN       = seen_q;
endmodule

// ===== verilog/prad_pkg.sv
package prad_pkg;
    localparam int unsigned AD_W        = 32;
    localparam int unsigned CBE_W       = 4;
    localparam int unsigned LANES       = 4;
    localparam int unsigned LANE_W      = 8;
    localparam int unsigned PAR_DELAY   = 1;
    localparam int unsigned PERR_EN_BIT = 6;
    localparam logic [7:0]  CMD_REG_OFS = 8'h04;
    localparam logic [31:0] AD_RST      = 32'h0000_0000;
    localparam logic [3:0]  CBE_RST     = 4'h0;
    localparam logic [15:0] CMD_RST     = 16'h0000;

    typedef enum logic [1:0] {
        PRAD_IDLE,
        PRAD_ADDR,
        PRAD_DATA
    } prad_phase_t;

    function automatic logic prad_even_par(input logic [31:0] ad, input logic [3:0] cbe);
        prad_even_par = ^{ad, cbe};
    endfunction

    function automatic logic [31:0] prad_lane_mask(input logic [3:0] be_n);
        logic [31:0] m;
        m = 32'h0000_0000;
        for (int i = 0; i < 4; i++) begin
            m[i*8 +: 8] = {8{~be_n[i]}};
        end
        prad_lane_mask = m;
    endfunction
endpackage

// ===== verilog/prad_if.sv
interface prad_if;
    logic [31:0] ad_host;
    logic        ad_host_oe;
    logic [31:0] ad_dev;
    logic        ad_dev_oe;
    logic [3:0]  cbe_host;
    logic        cbe_host_oe;
    logic [3:0]  cbe_dev;
    logic        cbe_dev_oe;
    logic        par_host;
    logic        par_host_oe;
    logic        par_dev;
    logic        par_dev_oe;
    logic        perr_n_dev;
    logic        perr_dev_oe;
    logic        addr_phase;
    logic        data_phase;
    logic        dev_initiator;
    logic        global_reset_in;
    logic        bus_reset_in;
    logic        suspend_in;
    logic [31:0] ad;
    logic [3:0]  cbe;
    logic        par;
    logic        perr_n;

    assign ad     = ad_dev_oe ? ad_dev : (ad_host_oe ? ad_host : 32'hFFFF_FFFF);
    assign cbe    = cbe_dev_oe ? cbe_dev : (cbe_host_oe ? cbe_host : 4'hF);
    assign par    = par_dev_oe ? par_dev : (par_host_oe ? par_host : 1'b1);
    assign perr_n = perr_dev_oe ? perr_n_dev : 1'b1;

    modport dev (
        input  ad, cbe, par, addr_phase, data_phase, dev_initiator,
        input  global_reset_in, bus_reset_in, suspend_in,
        output ad_dev, ad_dev_oe, cbe_dev, cbe_dev_oe, par_dev, par_dev_oe,
        output perr_n_dev, perr_dev_oe
    );
    modport host (
        input  ad, cbe, par, perr_n,
        output ad_host, ad_host_oe, cbe_host, cbe_host_oe, par_host, par_host_oe,
        output addr_phase, data_phase, dev_initiator,
        output global_reset_in, bus_reset_in, suspend_in
    );
endinterface

// ===== verilog/prad_host.sv
module prad_host (
    input  wire logic        CLK,
    input  wire logic        RSTN,
    prad_if.host             bus,
    input  wire logic        GLOBAL_RESET_IN_REQ,
    input  wire logic        BRST_REQ,
    input  wire logic        SUSP_REQ,
    input  wire logic        DEV_INIT,
    input  wire logic        START,
    input  wire logic [31:0] ADDR,
    input  wire logic [3:0]  CMD,
    input  wire logic [31:0] DATA,
    input  wire logic [3:0]  BE_N,
    input  wire logic        BAD_PAR,
    output logic             BUSY,
    output logic             PERR_OBS
);
    prad_pkg::prad_phase_t ph_q, ph_d;
    logic [31:0] ad_q,   ad_d;
    logic [3:0]  cbe_q,  cbe_d;
    logic        oe_q,   oe_d;
    logic        par_q,  par_d;
    logic        poe_q,  poe_d;
    logic [31:0] data_q, data_d;
    logic [3:0]  be_q,   be_d;
    logic        bad_q,  bad_d;
    logic        pobs_q, pobs_d;
    logic        own_q,  own_d;
    logic        g_q, b_q, s_q, di_q;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        ph_d   = ph_q;
        ad_d   = ad_q;
        cbe_d  = cbe_q;
        oe_d   = 1'b0;
        data_d = data_q;
        be_d   = be_q;
        bad_d  = bad_q;
        own_d  = own_q;
        par_d  = prad_pkg::prad_even_par(ad_q, cbe_q) ^ bad_q;
        poe_d  = oe_q;
        pobs_d = !bus.perr_n;
        unique case (ph_q)
            prad_pkg::PRAD_IDLE: begin
                if (START) begin
                    ph_d   = prad_pkg::PRAD_ADDR;
                    ad_d   = ADDR;
                    cbe_d  = CMD;
                    // Lanes stay free when the device initiates
                    oe_d   = !DEV_INIT;
                    own_d  = !DEV_INIT;
                    data_d = DATA;
                    be_d   = BE_N;
                    bad_d  = BAD_PAR;
                end
            end
            prad_pkg::PRAD_ADDR: begin
                ph_d  = prad_pkg::PRAD_DATA;
                ad_d  = data_q;
                cbe_d = be_q;
                oe_d  = own_q;
            end
            prad_pkg::PRAD_DATA: begin
                ph_d = prad_pkg::PRAD_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK) begin
        g_q  <= !RSTN || GLOBAL_RESET_IN_REQ;
        b_q  <= BRST_REQ;
        s_q  <= SUSP_REQ;
        di_q <= DEV_INIT;
        if (!RSTN) begin
            ph_q   <= prad_pkg::PRAD_IDLE;
            ad_q   <= prad_pkg::AD_RST;
            cbe_q  <= prad_pkg::CBE_RST;
            oe_q   <= 1'b0;
            par_q  <= 1'b0;
            poe_q  <= 1'b0;
            data_q <= prad_pkg::AD_RST;
            be_q   <= prad_pkg::CBE_RST;
            bad_q  <= 1'b0;
            pobs_q <= 1'b0;
            own_q  <= 1'b0;
        end else begin
            ph_q   <= ph_d;
            ad_q   <= ad_d;
            cbe_q  <= cbe_d;
            oe_q   <= oe_d;
            par_q  <= par_d;
            poe_q  <= poe_d;
            data_q <= data_d;
            be_q   <= be_d;
            bad_q  <= bad_d;
            pobs_q <= pobs_d;
            own_q  <= own_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign bus.ad_host         = ad_q;
    assign bus.ad_host_oe      = oe_q;
    assign bus.cbe_host        = cbe_q;
    assign bus.cbe_host_oe     = oe_q;
    assign bus.par_host        = par_q;
    assign bus.par_host_oe     = poe_q;
    assign bus.addr_phase      = (ph_q == prad_pkg::PRAD_ADDR);
    assign bus.data_phase      = (ph_q == prad_pkg::PRAD_DATA);
    assign bus.dev_initiator   = di_q;
    assign bus.global_reset_in = g_q;
    assign bus.bus_reset_in    = b_q;
    assign bus.suspend_in      = s_q;
    assign BUSY                = (ph_q != prad_pkg::PRAD_IDLE);
    assign PERR_OBS            = pobs_q;
endmodule

// ===== tb/prad_props.sv
module prad_props (
    input wire logic        CLK,
    input wire logic        RSTN,
    input wire logic [31:0] ad,
    input wire logic [3:0]  cbe,
    input wire logic        par,
    input wire logic        perr_n,
    input wire logic        ad_dev_oe,
    input wire logic        par_dev_oe,
    input wire logic        perr_dev_oe,
    input wire logic        ad_host_oe,
    input wire logic        par_host_oe,
    input wire logic        addr_phase,
    input wire logic        data_phase,
    input wire logic        dev_initiator,
    input wire logic        global_reset_in,
    input wire logic        bus_reset_in,
    input wire logic        suspend_in
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RSTN);
    logic dev_oe;
    assign dev_oe = ad_dev_oe | par_dev_oe | perr_dev_oe;
    ////////////////////////////////////////////////////////////////
    a_global_reset_in_float: assert property (global_reset_in |=> !dev_oe)
        else $error("device drives under global reset");
    a_brst_float: assert property (bus_reset_in |=> !dev_oe)
        else $error("device drives under bus reset");
    a_dev_par: assert property ($past(ad_dev_oe) && !$past(global_reset_in || bus_reset_in)
        |-> par_dev_oe && par == ^{$past(ad), $past(cbe)}) else $error("initiator parity wrong");
    a_perr_cause: assert property (!perr_n |-> $past(par) != ^{$past(ad, 2), $past(cbe, 2)})
        else $error("error flag without mismatch");
    a_phase_seq: assert property (addr_phase |=> data_phase ##1 !addr_phase)
        else $error("phase order broken");
    a_host_lanes: assert property ((addr_phase || data_phase) && !dev_initiator |-> ad_host_oe)
        else $error("lanes not driven in phase");
    a_host_par: assert property ($past(addr_phase || data_phase) && !$past(dev_initiator) |-> par_host_oe)
        else $error("parity not driven after lanes");
    a_dev_lanes: assert property (ad_dev_oe |-> $past(addr_phase || data_phase))
        else $error("device lanes without phase");
    c_perr: cover property (!perr_n);
    c_b2b: cover property (addr_phase ##3 addr_phase);
    c_keep: cover property (bus_reset_in && suspend_in);
    c_dev_par: cover property (par_dev_oe && !par);
endmodule

// ===== tb/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [31:0] a;
        logic [3:0]  c;
        logic [31:0] d;
        logic [3:0]  b;
        logic        bp;
        logic        en;
    } prad_row_t;
    logic        clk, rstn, global_reset_in_req, brst_req, susp_req, dev_init, start, bad_par, cfg_we;
    logic        rx_vld, perr_seen, busy, perr_obs, exp_seen, got_perr;
    logic [31:0] addr, data, rx_addr, rx_data, exp_rx, m;
    logic [3:0]  cmd, be_n, rx_cmd;
    logic [15:0] cfg_wdata, cfg_cmd;
    int          error_cnt, n_checks, i, n;
    prad_row_t   rows [6];
    prad_if bus ();
    prad_dev i_prad_dev (
        .CLK(clk), .RSTN(rstn), .bus(bus), .TX_ADDR(addr), .TX_CMD(cmd),
        .TX_DATA(data), .TX_BE_N(be_n), .CFG_WE(cfg_we), .CFG_CMD_WDATA(cfg_wdata),
        .CFG_CMD(cfg_cmd), .RX_ADDR(rx_addr), .RX_CMD(rx_cmd), .RX_DATA(rx_data),
        .RX_DATA_VLD(rx_vld), .PERR_SEEN(perr_seen)
    );
    prad_host i_prad_host (
        .CLK(clk), .RSTN(rstn), .bus(bus), .GLOBAL_RESET_IN_REQ(global_reset_in_req), .BRST_REQ(brst_req),
        .SUSP_REQ(susp_req), .DEV_INIT(dev_init), .START(start), .ADDR(addr), .CMD(cmd),
        .DATA(data), .BE_N(be_n), .BAD_PAR(bad_par), .BUSY(busy), .PERR_OBS(perr_obs)
    );
    prad_props i_prad_props (
        .CLK(clk), .RSTN(rstn), .ad(bus.ad), .cbe(bus.cbe), .par(bus.par), .perr_n(bus.perr_n),
        .ad_dev_oe(bus.ad_dev_oe), .par_dev_oe(bus.par_dev_oe), .perr_dev_oe(bus.perr_dev_oe),
        .ad_host_oe(bus.ad_host_oe), .par_host_oe(bus.par_host_oe), .addr_phase(bus.addr_phase),
        .data_phase(bus.data_phase), .dev_initiator(bus.dev_initiator),
        .global_reset_in(bus.global_reset_in),
        .bus_reset_in(bus.bus_reset_in), .suspend_in(bus.suspend_in)
    );
    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic cfg(input logic [15:0] v);
        @(posedge clk);
        cfg_we <= 1'b1;
        cfg_wdata <= v;
        @(posedge clk);
        cfg_we <= 1'b0;
        @(posedge clk);
        #1;
        chk(cfg_cmd, v);
    endtask
    task automatic xfer(input prad_row_t r);
        int k;
        @(posedge clk);
        start <= 1'b1;
        addr <= r.a;
        cmd <= r.c;
        data <= r.d;
        be_n <= r.b;
        bad_par <= r.bp;
        @(posedge clk);
        start <= 1'b0;
        got_perr = 1'b0;
        for (k = 0; k < 8 && rx_vld !== 1'b1; k++) begin
            @(posedge clk);
            #1;
            got_perr |= perr_obs;
        end
        if (k == 8) begin
            chk(1'b0, 1'b1);
            summarize();
        end
        repeat (4) begin
            @(posedge clk);
            #1;
            got_perr |= perr_obs;
        end
        for (k = 0; k < 4; k++)
            m[k*8 +: 8] = {8{~r.b[k]}};
        exp_rx = (exp_rx & ~m) | (r.d & m);
        exp_seen |= r.bp;
        chk(rx_addr, r.a);
        chk(rx_cmd, r.c);
        chk(rx_data, exp_rx);
        chk(got_perr, r.bp & r.en);
        chk(perr_seen, exp_seen);
    endtask
    task automatic rcase(input logic g, input logic b, input logic s, input logic keep);
        @(posedge clk);
        global_reset_in_req <= g;
        brst_req <= b;
        susp_req <= s;
        repeat (3) @(posedge clk);
        #1;
        chk(bus.ad, 32'hFFFF_FFFF);
        chk(bus.par, 1'b1);
        @(posedge clk);
        global_reset_in_req <= 1'b0;
        brst_req <= 1'b0;
        susp_req <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        if (!keep) begin
            exp_rx = 32'h0000_0000;
            exp_seen = 1'b0;
        end
        chk(cfg_cmd, keep ? 16'h0040 : 16'h0000);
        chk(rx_data, exp_rx);
        chk(perr_seen, exp_seen);
    endtask
    // Device as initiator, optionally cut by bus reset after the address
    task automatic dinit(input logic [31:0] a, input logic [3:0] c, input logic [31:0] d,
                         input logic [3:0] b, input logic cut);
        @(posedge clk);
        dev_init <= 1'b1;
        start <= 1'b1;
        addr <= a;
        cmd <= c;
        data <= d;
        be_n <= b;
        @(posedge clk);
        start <= 1'b0;
        brst_req <= cut;
        @(posedge clk);
        #1;
        chk(bus.ad, a);
        chk(bus.cbe, c);
        chk(busy, 1'b1);
        @(posedge clk);
        #1;
        if (cut) begin
            exp_rx = 32'h0000_0000;
            exp_seen = 1'b0;
            chk(bus.ad, 32'hFFFF_FFFF);
            chk(bus.par, 1'b1);
        end else begin
            chk(bus.ad, d);
            chk(bus.cbe, b);
            chk(bus.par, ^{a, c});
        end
        @(posedge clk);
        brst_req <= 1'b0;
        dev_init <= 1'b0;
        #1;
        chk(bus.par, cut ? 1'b1 : ^{d, b});
        chk(bus.ad, 32'hFFFF_FFFF);
        chk(busy, 1'b0);
        chk(rx_data, exp_rx);
        chk(perr_seen, exp_seen);
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        rows = '{'{32'h1234_5678, 4'h6, 32'hA5A5_0F0F, 4'h0, 1'b0, 1'b1},
                 '{32'h0000_0000, 4'h7, 32'hFFFF_FFFF, 4'hA, 1'b0, 1'b1},
                 '{32'hFFFF_FFFF, 4'hB, 32'h1111_2222, 4'hF, 1'b0, 1'b1},
                 '{32'h8000_0001, 4'h2, 32'h0102_0304, 4'h5, 1'b1, 1'b1},
                 '{32'h0F0F_0F0F, 4'hC, 32'hDEAD_BEEF, 4'h3, 1'b1, 1'b0},
                 '{32'h7FFF_FFFE, 4'h3, 32'hCAFE_F00D, 4'hE, 1'b0, 1'b0}};
        {rstn, global_reset_in_req, brst_req, susp_req, dev_init, start, bad_par, cfg_we} = 8'h00;
        {addr, data, cmd, be_n, cfg_wdata} = 88'h0;
        error_cnt = 0;
        n_checks = 0;
        exp_rx = 32'h0000_0000;
        exp_seen = 1'b0;
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        chk(cfg_cmd, 16'h0000);
        chk(rx_data, 32'h0000_0000);
        chk(bus.ad, 32'hFFFF_FFFF);
        for (n = 0; n < 6; n++) begin
            if (cfg_cmd[6] !== rows[n].en)
                cfg(rows[n].en ? 16'h0040 : 16'h0000);
            xfer(rows[n]);
        end
        // Held start gives one transfer per three clocks
        @(posedge clk);
        start <= 1'b1;
        i = 0;
        for (n = 0; n < 10; n++) begin
            @(posedge clk);
            if (n == 4)
                start <= 1'b0;
            #1;
            i += (bus.addr_phase === 1'b1);
        end
        chk(i, 2);
        dinit(32'h8421_0F3C, 4'h6, 32'h0123_4567, 4'h9, 1'b0);
        dinit(32'h5A5A_A5A5, 4'h3, 32'hF0F0_0F0F, 4'h0, 1'b1);
        cfg(16'h0040);
        rcase(1'b0, 1'b1, 1'b1, 1'b1);
        rcase(1'b0, 1'b1, 1'b0, 1'b0);
        cfg(16'h0040);
        xfer(rows[3]);
        rcase(1'b1, 1'b0, 1'b1, 1'b0);
        xfer(rows[0]);
        summarize();
    end
endmodule
